// ### design/dpn_pkg.sv
package dpn_pkg;

  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CRC_W = 10;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned NVM_DEPTH = 8;

  // Register offsets
  localparam logic [7:0] A_WIPER = 8'h10;
  localparam logic [7:0] A_UB1 = 8'h25;
  localparam logic [7:0] A_UB2 = 8'h26;
  localparam logic [7:0] A_STAT = 8'hd0;
  localparam logic [7:0] A_CFG = 8'hd1;
  localparam logic [7:0] A_PROT = 8'hd3;

  // Field positions
  localparam int unsigned BYTE_LSB = 4;
  localparam int unsigned CFG_LOCK = 13;
  localparam int unsigned CFG_PDN = 3;
  localparam int unsigned CFG_REF = 2;
  localparam int unsigned CFG_SPAN = 0;
  localparam int unsigned PR_KEY = 0;
  localparam int unsigned PR_ULK = 4;
  localparam int unsigned PR_STORE = 8;
  localparam int unsigned PR_RESTORE = 9;

  // Codes
  localparam logic [3:0] KEY_SOFT_RST = 4'ha;
  localparam logic [3:0] KEY_UNLOCK = 4'h5;
  localparam logic [1:0] PDN_UP = 2'h0;
  localparam logic [1:0] PDN_HIZ = 2'h2;
  localparam logic [CRC_W-1:0] CRC_POLY = 10'h233;
  localparam logic [CRC_W-1:0] CRC_INIT = 10'h000;

  // Nonvolatile word layout
  localparam logic [IDX_W-1:0] NV_CFG = 3'h0;
  localparam logic [IDX_W-1:0] NV_WIPER = 3'h1;
  localparam logic [IDX_W-1:0] NV_UB1 = 3'h2;
  localparam logic [IDX_W-1:0] NV_UB2 = 3'h3;
  localparam logic [IDX_W-1:0] NV_UCRC = 3'h4;
  localparam logic [IDX_W-1:0] NV_TRIM = 3'h5;
  localparam logic [IDX_W-1:0] NV_ICRC = 3'h6;

  // Timing: least program time, 250 MHz clock
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PROG_TIME_US = 10_000;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic lock;
    logic [1:0] pdn;
    logic ref_en;
    logic [1:0] span;
  } dpn_cfg_t;

  typedef struct packed {
    logic alm_int;
    logic alm_user;
    logic busy;
  } dpn_status_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_LOAD = 3'h1,
    S_APPLY = 3'h2,
    S_PROG = 3'h3,
    S_WAIT = 3'h4
  } dpn_state_t;

  // Factory values
  localparam dpn_cfg_t CFG_FACTORY = '{lock: 1'b0, pdn: PDN_HIZ, ref_en: 1'b0, span: 2'h0};
  localparam logic [7:0] BYTE_FACTORY = 8'h00;

  function automatic logic [15:0] byte_word(input logic [7:0] b);
    byte_word = 16'h0000;
    byte_word[BYTE_LSB +: 8] = b;
  endfunction

  function automatic logic [15:0] cfg_word(input dpn_cfg_t c);
    cfg_word = 16'h0000;
    cfg_word[CFG_LOCK] = c.lock;
    cfg_word[CFG_PDN +: 2] = c.pdn;
    cfg_word[CFG_REF] = c.ref_en;
    cfg_word[CFG_SPAN +: 2] = c.span;
  endfunction

  function automatic dpn_cfg_t word_cfg(input logic [15:0] w);
    word_cfg = '{lock: w[CFG_LOCK], pdn: w[CFG_PDN +: 2], ref_en: w[CFG_REF],
                 span: w[CFG_SPAN +: 2]};
  endfunction

  // Gain in half steps
  function automatic logic [3:0] span_half(input logic [1:0] s);
    case (s)
      2'h0: span_half = 4'h3;
      2'h1: span_half = 4'h4;
      2'h2: span_half = 4'h6;
      default: span_half = 4'h8;
    endcase
  endfunction

endpackage

// ### design/dpn_crc10.sv
module dpn_crc10
  import dpn_pkg::*;
#(
  parameter int unsigned DW = DATA_W
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Accumulate control
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [DW-1:0] data_i,
  // Running checksum
  output logic [CRC_W-1:0] crc_o
);

  logic [CRC_W-1:0] crc_q, crc_d;

  // Word fed MSB first, no final inversion
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic [DW-1:0] d);
    logic [CRC_W-1:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ d[i];
      r = {r[CRC_W-2:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    crc_step = r;
  endfunction

  assign crc_d = clr_i ? CRC_INIT : (en_i ? crc_step(crc_q, data_i) : crc_q);
  assign crc_o = crc_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

endmodule // dpn_crc10

// ### design/dpn_nvm.sv
module dpn_nvm #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned IW = 3
) (
  // Clock and array erase
  input wire logic clk_sys_i,
  input wire logic erase_i,
  // Word access
  input wire logic we_i,
  input wire logic [IW-1:0] idx_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] rdata_o
);

  // Not cleared by the system reset: contents survive it like real cells
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys_i or posedge erase_i) begin
    if (erase_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we_i) begin
      mem_q[idx_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[idx_i];

endmodule // dpn_nvm

// ### design/dpn_regctl.sv
// Notes on behaviour
// R1 - Wiper code is unsigned 0..255; output is code/256 times reference.
// R2 - Every reset or power-on loads all registers from nonvolatile storage.
// R3 - Out of reset the supply is the reference unless internal one enabled.
// R4 - Internal reference off by default; enable bit in configuration turns it on.
// R5 - Span field picks gain 1.5x, 2x, 3x or 4x on 1.21 V.
// R6 - New wiper code applies only when its whole write frame completes.
// R7 - Store trigger writes every backed field into nonvolatile storage.
// R8 - Busy flag high throughout any store or reload, low afterwards.
// R9 - All register writes ignored while busy; accepted again after.
// R10 - Host must not read the wiper register while busy.
// R11 - Restore trigger reloads from storage; bit self-clears when done.
// R12 - Two user bytes sit in bits 11:4 at 25h and 26h, backed.
// R13 - Checksum CRC-10 stored with data; checked on every load incl. startup.
// R14 - Separate checksum alarms for user region and internal region.
// R15 - On any alarm registers take factory values; access stays normal.
// R16 - Soft reset or power cycle clears alarms; power cycle reloads user data.
// R17 - Store trigger ignored while the internal-region alarm is set.
// R18 - Permanent storage failure keeps alarm set after reset via recheck.
// R19 - Key 1010 in protect register causes a full power-on reset.
// R20 - Lock bit refuses writes; unlock key 0101 in protect bypasses it.
// R21 - Powerdown 00 on, 01/11 to 10 kOhm, 10 high impedance default.
// R22 - Span codes 00 1.5x, 01 2x, 10 3x, 11 4x.
// R23 - Busy held and writes blocked during startup load and check.
module dpn_regctl
  import dpn_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register access, one pulse per completed serial frame
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_refused_o,
  // Storage maintenance and failure model
  input wire logic nvm_erase_i,
  input wire logic nvm_fault_user_i,
  input wire logic nvm_fault_internal_i,
  // Potentiometer controls
  output logic [7:0] wiper_code_o,
  output dpn_cfg_t cfg_o,
  output logic ref_internal_o,
  output logic [3:0] gain_half_o,
  output logic out_drive_o,
  output logic out_pull_10k_o,
  output logic out_hiz_o,
  // Status
  output dpn_status_t status_o
);

  localparam int unsigned TMR_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYCLES - 1);

  dpn_state_t state_q, state_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  dpn_cfg_t cfg_q, cfg_d;
  logic [7:0] wiper_q, wiper_d;
  logic [7:0] ub1_q, ub1_d;
  logic [7:0] ub2_q, ub2_d;
  logic [7:0] trim_q, trim_d;
  logic a_usr_q, a_usr_d;
  logic a_int_q, a_int_d;
  logic unlock_q, unlock_d;
  logic restore_q, restore_d;
  logic soft_q;
  logic busy_q;
  logic refused_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] rd_data_q, rd_d;
  logic [3:0] gain_q;
  logic drive_q, pull_q, hiz_q;

  logic locked, wr_ok;
  logic wr_wiper, wr_ub1, wr_ub2, wr_cfg, wr_prot;
  logic do_soft, do_ulk, do_store, do_restore;
  logic step, last, ld, fac;
  logic chk_usr, chk_int;
  logic f_usr, f_int;
  logic crc_clr, crc_en;
  logic [CRC_W-1:0] crc;
  logic [DATA_W-1:0] nv_raw, nv_rd, nv_wd, feed;

  // Write acceptance

  assign locked = cfg_q.lock && !unlock_q;
  // Protect stays writable when locked, else the unlock key could never land
  assign wr_ok = wr_i && !busy_q && (!locked || wr_addr_i == A_PROT); // [R9] [R20] [R23]
  assign wr_wiper = wr_ok && wr_addr_i == A_WIPER;
  assign wr_ub1 = wr_ok && wr_addr_i == A_UB1;
  assign wr_ub2 = wr_ok && wr_addr_i == A_UB2;
  assign wr_cfg = wr_ok && wr_addr_i == A_CFG;
  assign wr_prot = wr_ok && wr_addr_i == A_PROT;

  // Protect register triggers; soft reset outranks store, store outranks restore
  assign do_soft = wr_prot && wr_data_i[PR_KEY +: 4] == KEY_SOFT_RST; // [R19]
  assign do_ulk = wr_prot && wr_data_i[PR_ULK +: 4] == KEY_UNLOCK; // [R20]
  assign do_store = wr_prot && wr_data_i[PR_STORE] && !a_int_q && !do_soft; // [R7] [R17]
  assign do_restore = wr_prot && wr_data_i[PR_RESTORE] && !do_soft && !do_store; // [R11]

  // Storage sequencing

  assign step = state_q == S_LOAD || state_q == S_PROG;
  assign last = idx_q == NV_ICRC;
  assign ld = state_q == S_LOAD;
  assign chk_usr = ld && idx_q == NV_UCRC;
  assign chk_int = ld && idx_q == NV_ICRC;
  assign fac = state_q == S_APPLY && (a_usr_q || a_int_q); // [R15]

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (do_store) begin
          state_d = S_PROG; // [R7]
        end else if (do_restore) begin
          state_d = S_LOAD; // [R11]
        end
      end
      S_LOAD: begin
        if (last) begin
          state_d = S_APPLY;
        end
      end
      S_APPLY: begin
        state_d = S_IDLE;
      end
      S_PROG: begin
        if (last) begin
          state_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tmr_q == TMR_LAST) begin
          state_d = S_IDLE; // [R8]
        end
      end
      default: begin
        state_d = S_LOAD;
      end
    endcase
    if (soft_q) begin
      state_d = S_LOAD; // [R19] [R2]
    end
  end

  assign idx_d = (!step || last || soft_q) ? '0 : IDX_W'(idx_q + 1'b1);
  assign tmr_d = (state_q == S_WAIT) ? TMR_W'(tmr_q + 1'b1) : '0;

  // A permanent cell failure corrupts every read of its region
  assign f_usr = nvm_fault_user_i && idx_q <= NV_UCRC;
  assign f_int = nvm_fault_internal_i && idx_q >= NV_TRIM;
  assign nv_rd = nv_raw ^ {15'h0000, f_usr || f_int}; // [R18]

  // Image written on a store: user words, their checksum, then internal words
  always_comb begin
    case (idx_q)
      NV_CFG: nv_wd = cfg_word(cfg_q);
      NV_WIPER: nv_wd = byte_word(wiper_q);
      NV_UB1: nv_wd = byte_word(ub1_q); // [R12]
      NV_UB2: nv_wd = byte_word(ub2_q); // [R12]
      NV_TRIM: nv_wd = {8'h00, trim_q};
      default: nv_wd = {6'h00, crc}; // [R13]
    endcase
  end

  // Checksum runs over the same words on store and load; restarts per region
  assign crc_clr = !step || idx_q == NV_UCRC;
  assign crc_en = step && idx_q != NV_UCRC && idx_q != NV_ICRC;
  assign feed = ld ? nv_rd : nv_wd;

  dpn_crc10 #(
    .DW(DATA_W)
  ) u_crc (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clr_i(crc_clr),
    .en_i(crc_en),
    .data_i(feed),
    .crc_o(crc)
  );

  dpn_nvm #(
    .W(DATA_W),
    .DEPTH(NVM_DEPTH),
    .IW(IDX_W)
  ) u_nvm (
    .clk_sys_i(clk_sys_i),
    .erase_i(nvm_erase_i),
    .we_i(state_q == S_PROG), // [R7]
    .idx_i(idx_q),
    .wdata_i(nv_wd),
    .rdata_o(nv_raw)
  );

  // Alarms: cleared by soft reset, rewritten by each check
  assign a_usr_d = soft_q ? 1'b0 :
                   chk_usr ? (nv_rd != {6'h00, crc}) : a_usr_q; // [R13] [R14] [R16]
  assign a_int_d = soft_q ? 1'b0 :
                   chk_int ? (nv_rd != {6'h00, crc}) : a_int_q; // [R13] [R14] [R16]

  // Live registers: factory values win, then storage load, then host write
  assign cfg_d = fac ? CFG_FACTORY :
                 (ld && idx_q == NV_CFG) ? word_cfg(nv_rd) :
                 wr_cfg ? word_cfg(wr_data_i) : cfg_q; // [R2] [R4] [R15]
  // Frame data arrives whole, so the code never changes mid-frame
  assign wiper_d = fac ? BYTE_FACTORY :
                   (ld && idx_q == NV_WIPER) ? nv_rd[BYTE_LSB +: 8] :
                   wr_wiper ? wr_data_i[BYTE_LSB +: 8] : wiper_q; // [R1] [R6]
  assign ub1_d = fac ? BYTE_FACTORY :
                 (ld && idx_q == NV_UB1) ? nv_rd[BYTE_LSB +: 8] :
                 wr_ub1 ? wr_data_i[BYTE_LSB +: 8] : ub1_q; // [R12]
  assign ub2_d = fac ? BYTE_FACTORY :
                 (ld && idx_q == NV_UB2) ? nv_rd[BYTE_LSB +: 8] :
                 wr_ub2 ? wr_data_i[BYTE_LSB +: 8] : ub2_q; // [R12]
  assign trim_d = fac ? BYTE_FACTORY :
                  (ld && idx_q == NV_TRIM) ? nv_rd[7:0] : trim_q;

  // Bypass holds until a soft reset or the lock is written again
  assign unlock_d = soft_q ? 1'b0 :
                    do_ulk ? 1'b1 :
                    (wr_cfg && wr_data_i[CFG_LOCK]) ? 1'b0 : unlock_q; // [R20]
  assign restore_d = soft_q ? 1'b0 :
                     do_restore ? 1'b1 :
                     (state_q == S_APPLY) ? 1'b0 : restore_q; // [R11]

  // Register reads
  always_comb begin
    case (rd_addr_i)
      A_WIPER: rd_d = byte_word(wiper_q);
      A_UB1: rd_d = byte_word(ub1_q);
      A_UB2: rd_d = byte_word(ub2_q);
      A_STAT: rd_d = {13'h0000, a_int_q, a_usr_q, busy_q}; // [R8] [R14]
      A_CFG: rd_d = cfg_word(cfg_q);
      A_PROT: rd_d = {6'h00, restore_q, 9'h000};
      default: rd_d = 16'h0000;
    endcase
  end

  // Sequencer and alarms; reset starts straight in a load with busy high
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_LOAD; // [R2] [R23]
      idx_q <= '0;
      tmr_q <= '0;
      busy_q <= 1'b1; // [R23]
      soft_q <= 1'b0;
      a_usr_q <= 1'b0;
      a_int_q <= 1'b0;
      unlock_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      // Busy already rises with the reset key, so no write slips into a lost cycle
      busy_q <= state_d != S_IDLE || do_soft; // [R8] [R23]
      soft_q <= do_soft; // [R19]
      a_usr_q <= a_usr_d;
      a_int_q <= a_int_d;
      unlock_q <= unlock_d;
      restore_q <= restore_d;
    end
  end

  // Potentiometer registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= CFG_FACTORY;
      wiper_q <= BYTE_FACTORY;
      ub1_q <= BYTE_FACTORY;
      ub2_q <= BYTE_FACTORY;
      trim_q <= BYTE_FACTORY;
    end else begin
      cfg_q <= cfg_d;
      wiper_q <= wiper_d;
      ub1_q <= ub1_d;
      ub2_q <= ub2_d;
      trim_q <= trim_d;
    end
  end

  // Host answers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_i;
      refused_q <= wr_i && !wr_ok; // [R9] [R20]
      if (rd_i) begin
        rd_data_q <= rd_d;
      end
    end
  end

  // Analog controls trail the configuration register by one cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= span_half(CFG_FACTORY.span);
      drive_q <= 1'b0;
      pull_q <= 1'b0;
      hiz_q <= 1'b1;
    end else begin
      gain_q <= span_half(cfg_q.span); // [R5] [R22]
      drive_q <= cfg_q.pdn == PDN_UP; // [R21]
      hiz_q <= cfg_q.pdn == PDN_HIZ; // [R21]
      pull_q <= cfg_q.pdn != PDN_UP && cfg_q.pdn != PDN_HIZ; // [R21]
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign wr_refused_o = refused_q;
  assign wiper_code_o = wiper_q; // [R1]
  assign cfg_o = cfg_q;
  assign ref_internal_o = cfg_q.ref_en; // [R3] [R4]
  assign gain_half_o = gain_q;
  assign out_drive_o = drive_q;
  assign out_pull_10k_o = pull_q;
  assign out_hiz_o = hiz_q;
  assign status_o = '{alm_int: a_int_q, alm_user: a_usr_q, busy: busy_q};

endmodule // dpn_regctl

// ### tb/dpn_regctl_props.sv
module dpn_regctl_props
  import dpn_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register access
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic wr_refused_o,
  // Controls and status
  input wire logic [7:0] wiper_code_o,
  input wire dpn_cfg_t cfg_o,
  input wire logic [3:0] gain_half_o,
  input wire logic out_drive_o,
  input wire logic out_pull_10k_o,
  input wire logic out_hiz_o,
  input wire dpn_status_t status_o
);
  localparam int ST_MAX = PROG_CYCLES + 16;
  localparam logic [3:0] GAIN_TBL [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire open_wr = wr_i && !status_o.busy;
  // A soft reset key overrides both triggers, so it is left out here
  wire prot_wr = open_wr && wr_addr_i == A_PROT && wr_data_i[3:0] != KEY_SOFT_RST;

  sequence s_load;
    status_o.busy [*8] ##1 !status_o.busy;
  endsequence
  sequence s_store;
    status_o.busy [*8] ##[1:ST_MAX] !status_o.busy;
  endsequence

  property p_boot; $fell(rst_i) |-> s_load; endproperty
  a_boot: assert property (p_boot) else $error("busy not held over load");
  property p_store; prot_wr && wr_data_i[8] && !status_o.alm_int |=> s_store; endproperty
  a_store: assert property (p_store) else $error("store busy span wrong");
  property p_rest;
    prot_wr && wr_data_i[9:8] == 2'b10 |=> status_o.busy [*7] ##[1:3] !status_o.busy;
  endproperty
  a_rest: assert property (p_rest) else $error("restore busy span wrong");
  property p_blk; prot_wr && wr_data_i[9:8] == 2'b01 && status_o.alm_int |=> !status_o.busy;
  endproperty
  a_blk: assert property (p_blk) else $error("store ran under alarm");
  property p_busy_ref; wr_i && status_o.busy |=> wr_refused_o; endproperty
  a_busy_ref: assert property (p_busy_ref) else $error("write taken while busy");
  property p_why;
    wr_refused_o |-> $past(wr_i) && ($past(status_o.busy) || $past(cfg_o.lock));
  endproperty
  a_why: assert property (p_why) else $error("refusal without cause");
  property p_wiper;
    open_wr && !cfg_o.lock && wr_addr_i == A_WIPER |=> wiper_code_o == $past(wr_data_i[11:4]);
  endproperty
  a_wiper: assert property (p_wiper) else $error("wiper not applied");
  property p_hold; !wr_i && !status_o.busy |=> $stable(wiper_code_o); endproperty
  a_hold: assert property (p_hold) else $error("wiper moved with no frame");
  property p_stat;
    rd_i && rd_addr_i == A_STAT |=> rd_valid_o && rd_data_o == {13'h0000, $past(status_o)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_rdw;
    rd_i && rd_addr_i == A_WIPER && !status_o.busy |=>
      rd_data_o == {4'h0, $past(wiper_code_o), 4'h0};
  endproperty
  a_rdw: assert property (p_rdw) else $error("wiper read wrong");
  property p_pdn;
    out_hiz_o == ($past(cfg_o.pdn) == PDN_HIZ) && out_drive_o == ($past(cfg_o.pdn) == PDN_UP)
      && out_pull_10k_o == $past(cfg_o.pdn[0]);
  endproperty
  a_pdn: assert property (p_pdn) else $error("powerdown decode wrong");
  property p_gain; gain_half_o == GAIN_TBL[$past(cfg_o.span)]; endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
endmodule // dpn_regctl_props

bind dpn_regctl dpn_regctl_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_i(wr_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .rd_i(rd_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .wr_refused_o(wr_refused_o), .wiper_code_o(wiper_code_o),
  .cfg_o(cfg_o), .gain_half_o(gain_half_o), .out_drive_o(out_drive_o),
  .out_pull_10k_o(out_pull_10k_o), .out_hiz_o(out_hiz_o), .status_o(status_o)
);

// ### tb/dpn_host_model.sv
module dpn_host_model
  import dpn_pkg::*;
(
  // Clock and device answers
  input wire logic clk_sys_i,
  input wire dpn_status_t status_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  // Register requests
  output logic wr_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic rd_o,
  output logic [ADDR_W-1:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 16'h0000;
    rd_addr_o = 8'h00;
  end
  // Fields are inverted after a frame so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    wr_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(posedge clk_sys_i);
    #1;
    wr_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    // Wiper is mid-load while busy, so hold off
    while (a == A_WIPER && status_i.busy) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
    rd_o = 1'b1;
    rd_addr_o = a;
    @(posedge clk_sys_i);
    #1;
    rd_o = 1'b0;
    rd_addr_o = ~a;
    d = rd_valid_i ? rd_data_i : 16'hxxxx;
  endtask
endmodule // dpn_host_model

// ### tb/dpn_regctl_tb_top.sv
module dpn_regctl_tb_top
  import dpn_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PROG = 20;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic erase = 1'b1;
  logic flt_u = 1'b0;
  logic flt_i = 1'b0;
  logic wr, rd, rd_valid, refused, ref_int, drv, pull, hiz;
  logic [7:0] wr_addr, rd_addr, wiper, w, k;
  logic [15:0] wr_data, rd_data;
  logic [3:0] gain;
  dpn_cfg_t cfg;
  dpn_status_t status;
  int fails = 0;
  int n_compared = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  dpn_regctl #(.PROG_CYCLES(PROG)) u_dpn_regctl (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_i(wr), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .rd_i(rd), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .wr_refused_o(refused), .nvm_erase_i(erase),
    .nvm_fault_user_i(flt_u), .nvm_fault_internal_i(flt_i), .wiper_code_o(wiper),
    .cfg_o(cfg), .ref_internal_o(ref_int), .gain_half_o(gain), .out_drive_o(drv),
    .out_pull_10k_o(pull), .out_hiz_o(hiz), .status_o(status)
  );
  dpn_host_model u_dpn_host_model (
    .clk_sys_i(clk_sys_i), .status_i(status), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .wr_o(wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_o(rd), .rd_addr_o(rd_addr)
  );

  function automatic logic [15:0] word(input logic [7:0] b);
    return {4'h0, b, 4'h0};
  endfunction
  function automatic logic [3:0] exp_gain(input logic [1:0] s);
    case (s)
      2'h0: return 4'h3;
      2'h1: return 4'h4;
      2'h2: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    u_dpn_host_model.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_dpn_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status.busy !== 1'b0 && n < 500) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(16'(status.busy), 16'h0000);
  endtask
  task automatic soft_rst();
    wr_reg(A_PROT, {12'h000, KEY_SOFT_RST});
    // Give the key two cycles to start the reload before polling busy
    repeat (2) @(posedge clk_sys_i);
    #1;
    wait_idle();
  endtask

  // Whole run is well under two thousand cycles
  initial begin
    #40us;
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(87583));
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    erase = 1'b0;
    wait_idle();
    rchk(A_STAT, 16'h0000);
    rchk(A_CFG, 16'h0000);
    chk(16'(ref_int), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr_reg(A_WIPER, word(w));
      chk(16'(wiper), 16'(w));
      rchk(A_WIPER, word(w));
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(A_CFG, 16'(i * 9) | 16'h0004);
      @(posedge clk_sys_i);
      #1;
      chk(16'(gain), 16'(exp_gain(2'(i))));
      chk(16'({drv, pull, hiz}), 16'({i == 0, i[0], i == 2}));
      chk(16'(ref_int), 16'h0001);
    end
    k = 8'($urandom);
    wr_reg(A_UB1, word(k));
    wr_reg(A_UB2, word(~k));
    rchk(A_UB1, word(k));
    rchk(A_UB2, word(~k));
    rchk(8'h40, 16'h0000);
    wr_reg(A_CFG, 16'h2000);
    wr_reg(A_WIPER, word(8'h5a));
    chk(16'(refused), 16'h0001);
    chk(16'(wiper), 16'(w));
    wr_reg(A_PROT, 16'h0050);
    wr_reg(A_WIPER, word(8'h5a));
    chk(16'(wiper), 16'h005a);
    wr_reg(A_CFG, 16'h0000);
    w = 8'h5a;
    wr_reg(A_PROT, 16'h0100);
    chk(16'(status.busy), 16'h0001);
    wr_reg(A_WIPER, word(8'h11));
    chk(16'(refused), 16'h0001);
    wait_idle();
    wr_reg(A_WIPER, word(8'h11));
    chk(16'(wiper), 16'h0011);
    wr_reg(A_PROT, 16'h0200);
    rchk(A_PROT, 16'h0200);
    wait_idle();
    rchk(A_PROT, 16'h0000);
    rchk(A_WIPER, word(w));
    rchk(A_UB2, word(~k));
    wr_reg(A_WIPER, word(8'h22));
    soft_rst();
    rchk(A_WIPER, word(w));
    flt_i = 1'b1;
    soft_rst();
    rchk(A_STAT, 16'h0004);
    chk(16'({wiper, hiz}), 16'h0001);
    wr_reg(A_PROT, 16'h0100);
    chk(16'(status.busy), 16'h0000);
    wr_reg(A_UB1, word(8'h77));
    rchk(A_UB1, word(8'h77));
    rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    wait_idle();
    rchk(A_STAT, 16'h0004);
    flt_i = 1'b0;
    flt_u = 1'b1;
    soft_rst();
    rchk(A_STAT, 16'h0002);
    flt_u = 1'b0;
    soft_rst();
    rchk(A_STAT, 16'h0000);
    rchk(A_WIPER, word(w));
    close_out();
  end
endmodule // dpn_regctl_tb_top
